/* File: hdl/pulse_command_scaling_defs.vh */
// Constants for the command pulse multiplier and electronic gear block
`ifndef PULSE_COMMAND_SCALING_DEFS_VH
`define PULSE_COMMAND_SCALING_DEFS_VH

// Register byte offsets
`define REG_CONTROL       8'h00
`define REG_FACTOR        8'h04
`define REG_GEAR_NUM      8'h08
`define REG_GEAR_DEN      8'h0C
`define REG_EVENT_STATUS  8'h10
`define REG_EVENT_MASK    8'h14
`define REG_POSITION      8'h18
`define REG_LIVE_STATUS   8'h1C

// Control register fields
`define CTL_MSEL_LSB      0
`define CTL_FORM_LSB      4
`define CTL_SRC_LSB       8

// Reset values
`define MSEL_RESET        2'h0
`define FORM_RESET        3'h0
`define SRC_RESET         2'h0
`define FACTOR_RESET      7'h01
`define GEAR_NUM_RESET    32'h00000001
`define GEAR_DEN_RESET    32'h00000001

// Multiplier selection codes
`define MSEL_OFF          2'h0
`define MSEL_FORCED       2'h1
`define MSEL_PIN          2'h2

// Input form codes
`define FORM_PULSE_DIR    3'h0
`define FORM_CW_CCW       3'h1
`define FORM_QUAD4        3'h4

// Command source codes
`define SRC_EXT_LOW       2'h0
`define SRC_EXT_HIGH      2'h1
`define SRC_INTERNAL      2'h3

// Multiplier factor range
`define FACTOR_MIN        7'h01
`define FACTOR_MAX        7'h64

// Gear ratio limits: 0.001 <= num/den <= 64000
`define GEAR_MIN_SCALE    48'h0000000003E8
`define GEAR_MAX_RATIO    48'h00000000FA00

// Counts per revolution used when the numerator is zero
`define ENCODER_COUNTS    40'h0001000000

// Event status bits
`define EVT_GEAR_FAULT    0
`define EVT_SWITCH_BUSY   1
`define EVT_WIDTH         2

// Cycles without a pulse before the pulse stream counts as idle
`define QUIET_CYCLES      8'h10

// AXI responses
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

/* File: hdl/pulse_decoder.v */
// Command pulse decoder for pulse/direction, CW/CCW and 4x quadrature
`timescale 1ns/1ps
module pulse_decoder (
    input  wire       aclk,
    input  wire       aresetn,
    input  wire       line_a,
    input  wire       line_b,
    input  wire [2:0] form,
    output reg        step,
    output reg        reverse
);
`include "pulse_command_scaling_defs.vh"

    reg  a_q_r;
    reg  b_q_r;
    wire a_rise = line_a & ~a_q_r;
    wire b_rise = line_b & ~b_q_r;
    wire a_edge = line_a ^ a_q_r;
    wire b_edge = line_b ^ b_q_r;

    always @(posedge aclk) begin
        if (!aresetn) begin
            a_q_r   <= 1'b0;
            b_q_r   <= 1'b0;
            step    <= 1'b0;
            reverse <= 1'b0;
        end else begin
            a_q_r   <= line_a;
            b_q_r   <= line_b;
            step    <= 1'b0;
            reverse <= 1'b0;
            case (form)
                `FORM_PULSE_DIR: begin
                    // Count on pulse rising edge, direction line high
                    // means reverse
                    step    <= a_rise;
                    reverse <= line_b;
                end
                `FORM_CW_CCW: begin
                    // Both lines at once cancel out
                    step    <= a_rise ^ b_rise;
                    reverse <= b_rise;
                end
                `FORM_QUAD4: begin
                    // Every edge counts; A leading B is forward.
                    // A double edge is an invalid jump and is dropped.
                    step    <= a_edge ^ b_edge;
                    reverse <= a_edge ? (line_a == line_b)
                                      : (line_a != line_b);
                end
                default: begin
                    step    <= 1'b0;
                    reverse <= 1'b0;
                end
            endcase
        end
    end

endmodule // pulse_decoder

/* File: hdl/pulse_command_scaling.v */
// Command pulse multiplier and electronic gear with AXI4-Lite registers
`timescale 1ns/1ps
module pulse_command_scaling (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        pulse_line_a,
    input  wire        pulse_line_b,
    input  wire        multiplier_switch,
    input  wire        position_mode,
    input  wire        internal_step,
    input  wire        internal_reverse,
    output reg         multiplier_active_out,
    output reg         parameter_fault_alarm,
    output reg         delta_valid,
    output reg  [31:0] delta_counts,
    output wire        irq
);
`include "pulse_command_scaling_defs.vh"

    ////////////////////////////////////////////////////////////////////////
    // Functions

    function [31:0] merge_bytes;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0]  strb;
        integer i;
        begin
            merge_bytes = old_v;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    merge_bytes[i*8 +: 8] = new_v[i*8 +: 8];
                end
            end
        end
    endfunction

    function [6:0] clamp_factor;
        input [31:0] v;
        begin
            if (v < {25'h0, `FACTOR_MIN}) begin
                clamp_factor = `FACTOR_MIN;
            end else if (v > {25'h0, `FACTOR_MAX}) begin
                clamp_factor = `FACTOR_MAX;
            end else begin
                clamp_factor = v[6:0];
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Registers

    reg  [1:0]           msel_r;
    reg  [2:0]           form_r;
    reg  [1:0]           src_r;
    reg  [6:0]           factor_r;
    reg  [31:0]          gear_num_r;
    reg  [31:0]          gear_den_r;
    reg  [`EVT_WIDTH-1:0] evt_status_r;
    reg  [`EVT_WIDTH-1:0] evt_mask_r;
    reg  [31:0]          position_r;
    reg  [39:0]          rem_r;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: value changes once stages two and three agree

    reg  [2:0] sync_a_r;
    reg  [2:0] sync_b_r;
    reg  [2:0] sync_sw_r;
    reg        line_a_r;
    reg        line_b_r;
    reg        switch_r;

    always @(posedge aclk) begin
        if (!aresetn) begin
            sync_a_r  <= 3'h0;
            sync_b_r  <= 3'h0;
            sync_sw_r <= 3'h0;
            line_a_r  <= 1'b0;
            line_b_r  <= 1'b0;
            switch_r  <= 1'b0;
        end else begin
            sync_a_r  <= {sync_a_r[1:0], pulse_line_a};
            sync_b_r  <= {sync_b_r[1:0], pulse_line_b};
            sync_sw_r <= {sync_sw_r[1:0], multiplier_switch};
            if (sync_a_r[1] == sync_a_r[2]) line_a_r <= sync_a_r[2];
            if (sync_b_r[1] == sync_b_r[2]) line_b_r <= sync_b_r[2];
            if (sync_sw_r[1] == sync_sw_r[2]) switch_r <= sync_sw_r[2];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pulse decode and source selection

    wire ext_step;
    wire ext_reverse;

    pulse_decoder u_decoder (
        .aclk    (aclk),
        .aresetn (aresetn),
        .line_a  (line_a_r),
        .line_b  (line_b_r),
        .form    (form_r),
        .step    (ext_step),
        .reverse (ext_reverse)
    );

    reg cmd_step;
    reg cmd_reverse;

    always @* begin
        case (src_r)
            `SRC_EXT_LOW, `SRC_EXT_HIGH: begin
                cmd_step    = ext_step;
                cmd_reverse = ext_reverse;
            end
            `SRC_INTERNAL: begin
                cmd_step    = internal_step;
                cmd_reverse = internal_reverse;
            end
            default: begin
                cmd_step    = 1'b0;
                cmd_reverse = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Multiplier selection

    reg mult_active;

    always @* begin
        case (msel_r)
            `MSEL_FORCED: mult_active = 1'b1;
            `MSEL_PIN:    mult_active = switch_r & position_mode;
            default:      mult_active = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Electronic gear with carried remainder

    wire [39:0] num_eff = (gear_num_r == 32'h0) ? `ENCODER_COUNTS
                                               : {8'h00, gear_num_r};
    wire [39:0] den_eff = (gear_den_r == 32'h0) ? 40'h0000000001
                                               : {8'h00, gear_den_r};
    // Ratio test: num*1000 >= den and num <= den*64000
    wire [47:0] num_scaled = {8'h00, num_eff} * `GEAR_MIN_SCALE;
    wire [47:0] den_scaled = {16'h0000, gear_den_r} * `GEAR_MAX_RATIO;
    wire gear_bad = (gear_den_r == 32'h0)
                  || (num_scaled[47:0] < {16'h0000, gear_den_r})
                  || ({8'h00, num_eff} > den_scaled);

    wire [6:0]  k_eff = mult_active ? factor_r : `FACTOR_MIN;
    wire [46:0] prod  = {40'h0, k_eff} * {7'h00, num_eff};

    reg  [47:0] t_sum;
    reg  [47:0] quot;
    reg  [47:0] rem_nxt;

    always @* begin
        t_sum   = 48'h0;
        quot    = 48'h0;
        rem_nxt = {8'h00, rem_r};
        if (!cmd_reverse) begin
            t_sum   = {8'h00, rem_r} + {1'b0, prod};
            quot    = t_sum / {8'h00, den_eff};
            rem_nxt = t_sum - quot * {8'h00, den_eff};
        end else if ({1'b0, prod} <= {8'h00, rem_r}) begin
            rem_nxt = {8'h00, rem_r} - {1'b0, prod};
        end else begin
            // Backing over zero borrows whole denominators
            t_sum   = {1'b0, prod} - {8'h00, rem_r};
            quot    = (t_sum + {8'h00, den_eff} - 48'h1)
                      / {8'h00, den_eff};
            rem_nxt = quot * {8'h00, den_eff} - t_sum;
        end
    end

    wire [31:0] step_delta = cmd_reverse ? (32'h0 - quot[31:0])
                                         : quot[31:0];

    ////////////////////////////////////////////////////////////////////////
    // Pulse activity, for spotting switches under way

    reg [7:0] quiet_r;
    reg       active_q_r;
    reg       fault_q_r;
    wire      pulses_busy = (quiet_r != 8'h00);
    // Reported only; the switch itself is the controller's duty
    wire      switch_evt  = (mult_active != active_q_r) & pulses_busy;
    wire      fault_evt   = gear_bad & ~fault_q_r;

    always @(posedge aclk) begin
        if (!aresetn) begin
            quiet_r               <= 8'h00;
            active_q_r            <= 1'b0;
            fault_q_r             <= 1'b0;
            multiplier_active_out <= 1'b0;
            parameter_fault_alarm <= 1'b0;
            delta_valid           <= 1'b0;
            delta_counts          <= 32'h0;
            position_r            <= 32'h0;
            rem_r                 <= 40'h0;
        end else begin
            active_q_r            <= mult_active;
            fault_q_r             <= gear_bad;
            multiplier_active_out <= mult_active;
            parameter_fault_alarm <= gear_bad;
            delta_valid           <= cmd_step;
            if (cmd_step) begin
                quiet_r      <= `QUIET_CYCLES;
                delta_counts <= step_delta;
                position_r   <= position_r + step_delta;
                rem_r        <= rem_nxt[39:0];
            end else if (pulses_busy) begin
                quiet_r <= quiet_r - 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave

    reg  [7:0]  awaddr_r;
    reg         aw_held_r;
    reg  [31:0] wdata_r;
    reg  [3:0]  wstrb_r;
    reg         w_held_r;

    assign s_axi_awready = ~aw_held_r & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held_r & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;

    wire aw_in    = s_axi_awvalid & s_axi_awready;
    wire w_in     = s_axi_wvalid & s_axi_wready;
    wire have_aw  = aw_held_r | aw_in;
    wire have_w   = w_held_r | w_in;
    wire do_write = have_aw & have_w;
    wire [7:0]  wr_addr = aw_held_r ? awaddr_r : s_axi_awaddr;
    wire [31:0] wr_data = w_held_r ? wdata_r : s_axi_wdata;
    wire [3:0]  wr_strb = w_held_r ? wstrb_r : s_axi_wstrb;

    wire [31:0] ctl_word = {22'h0, src_r, 1'b0, form_r, 2'h0, msel_r};
    wire [31:0] ctl_new  = merge_bytes(ctl_word, wr_data, wr_strb);
    wire [31:0] fac_new  = merge_bytes({25'h0, factor_r}, wr_data, wr_strb);
    wire [31:0] clr_bits = merge_bytes(32'h0, wr_data, wr_strb);
    wire [`EVT_WIDTH-1:0] evt_set = {switch_evt, fault_evt};
    wire wr_ok = (wr_addr == `REG_CONTROL) || (wr_addr == `REG_FACTOR)
              || (wr_addr == `REG_GEAR_NUM) || (wr_addr == `REG_GEAR_DEN)
              || (wr_addr == `REG_EVENT_STATUS)
              || (wr_addr == `REG_EVENT_MASK);

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r    <= 1'b0;
            w_held_r     <= 1'b0;
            awaddr_r     <= 8'h00;
            wdata_r      <= 32'h0;
            wstrb_r      <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RESP_OKAY;
            msel_r       <= `MSEL_RESET;
            form_r       <= `FORM_RESET;
            src_r        <= `SRC_RESET;
            factor_r     <= `FACTOR_RESET;
            gear_num_r   <= `GEAR_NUM_RESET;
            gear_den_r   <= `GEAR_DEN_RESET;
            evt_mask_r   <= {`EVT_WIDTH{1'b0}};
            evt_status_r <= {`EVT_WIDTH{1'b0}};
        end else begin
            if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
            if (aw_in && !do_write) begin
                aw_held_r <= 1'b1;
                awaddr_r  <= s_axi_awaddr;
            end
            if (w_in && !do_write) begin
                w_held_r <= 1'b1;
                wdata_r  <= s_axi_wdata;
                wstrb_r  <= s_axi_wstrb;
            end
            // New events win over a clear in the same cycle
            evt_status_r <= evt_status_r | evt_set;
            if (do_write) begin
                aw_held_r    <= 1'b0;
                w_held_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
                case (wr_addr)
                    `REG_CONTROL: begin
                        msel_r <= ctl_new[`CTL_MSEL_LSB +: 2];
                        form_r <= ctl_new[`CTL_FORM_LSB +: 3];
                        src_r  <= ctl_new[`CTL_SRC_LSB +: 2];
                    end
                    `REG_FACTOR:   factor_r <= clamp_factor(fac_new);
                    `REG_GEAR_NUM: gear_num_r <=
                        merge_bytes(gear_num_r, wr_data, wr_strb);
                    `REG_GEAR_DEN: gear_den_r <=
                        merge_bytes(gear_den_r, wr_data, wr_strb);
                    `REG_EVENT_STATUS: evt_status_r <=
                        (evt_status_r & ~clr_bits[`EVT_WIDTH-1:0]) | evt_set;
                    `REG_EVENT_MASK: evt_mask_r <=
                        clr_bits[`EVT_WIDTH-1:0];
                    default: ;
                endcase
            end
        end
    end

    assign irq = |(evt_status_r & evt_mask_r);

    ////////////////////////////////////////////////////////////////////////
    // Read channel

    reg [31:0] rd_word;
    reg        rd_ok;

    always @* begin
        rd_ok = 1'b1;
        case (s_axi_araddr)
            `REG_CONTROL:      rd_word = ctl_word;
            `REG_FACTOR:       rd_word = {25'h0, factor_r};
            `REG_GEAR_NUM:     rd_word = gear_num_r;
            `REG_GEAR_DEN:     rd_word = gear_den_r;
            `REG_EVENT_STATUS: rd_word = {30'h0, evt_status_r};
            `REG_EVENT_MASK:   rd_word = {30'h0, evt_mask_r};
            `REG_POSITION:     rd_word = position_r;
            `REG_LIVE_STATUS:  rd_word = {28'h0, pulses_busy, switch_r,
                                          parameter_fault_alarm,
                                          multiplier_active_out};
            default: begin
                rd_word = 32'h0;
                rd_ok   = 1'b0;
            end
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule // pulse_command_scaling

/* File: test/pulse_command_scaling_asserts.sv */
// Port checker for the pulse command scaling block
`timescale 1ns/1ps
module scaling_checker (
    input wire        aclk,
    input wire        aresetn,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire        pulse_line_a,
    input wire        pulse_line_b,
    input wire        multiplier_switch,
    input wire        position_mode,
    input wire        internal_step,
    input wire        multiplier_active_out,
    input wire        parameter_fault_alarm,
    input wire        delta_valid,
    input wire [31:0] delta_counts,
    input wire        irq
);
default clocking cb @(posedge aclk); endclocking
default disable iff (!aresetn);
////////////////////////////////////////////////////////////////////////////
// Cycles since a pin edge and since a config change, saturating
reg       pa_r, pb_r, sw_r, md_r;
reg [3:0] pin_age_r, cfg_age_r;
always @(posedge aclk) begin
    pa_r <= pulse_line_a;
    pb_r <= pulse_line_b;
    sw_r <= multiplier_switch;
    md_r <= position_mode;
    if (!aresetn || pa_r != pulse_line_a || pb_r != pulse_line_b)
        pin_age_r <= 4'h0;
    else if (pin_age_r != 4'hF)
        pin_age_r <= pin_age_r + 4'h1;
    if (!aresetn || (s_axi_awvalid && s_axi_awready) ||
        sw_r != multiplier_switch || md_r != position_mode)
        cfg_age_r <= 4'h0;
    else if (cfg_age_r != 4'hF)
        cfg_age_r <= cfg_age_r + 4'h1;
end
////////////////////////////////////////////////////////////////////////////
aw_refused_a: assert property (s_axi_bvalid |-> !s_axi_awready &&
    !s_axi_wready) else $error("write channels open during response");
write_resp_a: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write response late");
read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("read response late");
bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
delta_cause_a: assert property (
    delta_valid |-> $past(internal_step) || pin_age_r <= 4'h8)
    else $error("delta without a pulse");
delta_stable_a: assert property (
    !delta_valid |-> $stable(delta_counts))
    else $error("delta counts moved without valid");
active_cause_a: assert property (
    $changed(multiplier_active_out) |-> cfg_age_r <= 4'h8 ||
    md_r != position_mode)
    else $error("multiplier status moved without cause");
alarm_cause_a: assert property (
    $changed(parameter_fault_alarm) |-> cfg_age_r <= 4'h8)
    else $error("alarm moved without a gear write");
cover property (delta_valid && delta_counts[31]);
cover property ($rose(parameter_fault_alarm));
cover property ($rose(multiplier_active_out));
cover property (irq);
endmodule // scaling_checker

bind pulse_command_scaling scaling_checker chk (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .s_axi_rready, .pulse_line_a, .pulse_line_b, .multiplier_switch,
    .position_mode, .internal_step, .multiplier_active_out,
    .parameter_fault_alarm, .delta_valid, .delta_counts, .irq
);

/* File: test/upper_controller.sv */
// Upper controller model emitting command pulse trains
`timescale 1ns/1ps
module upper_controller (
    input  wire       aclk,
    input  wire [2:0] form,
    output reg        line_a,
    output reg        line_b
);
reg [1:0] phase_r;
initial begin
    line_a = 1'b0;
    line_b = 1'b0;
    phase_r = 2'h0;
end
// Four cycles a level, above the three-flop filter
task hold;
    repeat (4) @(posedge aclk);
endtask
task emit(input rev, input integer n);
    integer i;
    for (i = 0; i < n; i = i + 1) begin
        if (form == 3'h4) begin
            phase_r = rev ? phase_r - 2'h1 : phase_r + 2'h1;
            line_a <= phase_r[0] ^ phase_r[1];
            line_b <= phase_r[1];
            hold;
        end else if (form == 3'h1) begin
            if (rev) line_b <= 1'b1;
            else line_a <= 1'b1;
            hold;
            line_a <= 1'b0;
            line_b <= 1'b0;
            hold;
        end else begin
            line_b <= rev;
            hold;
            line_a <= 1'b1;
            hold;
            line_a <= 1'b0;
            hold;
        end
    end
    // Direction back low so a later form change sees no edge
    if (form == 3'h0) begin
        line_b <= 1'b0;
        hold;
    end
endtask
endmodule // upper_controller

/* File: test/tb_top.sv */
// Self-checking bench for the pulse command scaling block
`timescale 1ns/1ps
module tb_top;
reg         aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
reg         s_axi_arvalid, s_axi_rready, multiplier_switch, position_mode;
reg         internal_step, internal_reverse;
reg  [7:0]  s_axi_awaddr, s_axi_araddr;
reg  [31:0] s_axi_wdata, sum, rd_data;
reg  [2:0]  form;
reg  [1:0]  resp;
wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
wire        s_axi_rvalid, pulse_line_a, pulse_line_b, irq;
wire        multiplier_active_out, parameter_fault_alarm, delta_valid;
wire [1:0]  s_axi_bresp, s_axi_rresp;
wire [31:0] s_axi_rdata, delta_counts;
integer     num_errors, checked, cnt;
pulse_command_scaling dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pulse_line_a,
    .pulse_line_b, .multiplier_switch, .position_mode, .internal_step,
    .internal_reverse, .multiplier_active_out, .parameter_fault_alarm,
    .delta_valid, .delta_counts, .irq);
upper_controller host (.aclk, .form, .line_a(pulse_line_a),
    .line_b(pulse_line_b));
initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
end
always @(posedge aclk)
    if (!aresetn) begin
        sum <= 32'h0;
        cnt <= 0;
    end else if (delta_valid) begin
        sum <= sum + delta_counts;
        cnt <= cnt + 1;
    end
////////////////////////////////////////////////////////////////////////////
task cyc(input integer n);
    repeat (n) @(posedge aclk);
endtask
task chk(input [31:0] got, input [31:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
endtask
task wr(input [7:0] a, input [31:0] d);
    reg aw_go, w_go, done;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    done = 1'b0;
    while (!done) begin
        // Settled mid-cycle, so these are what the next edge sees
        @(negedge aclk);
        aw_go = s_axi_awvalid && s_axi_awready;
        w_go = s_axi_wvalid && s_axi_wready;
        done = s_axi_bvalid;
        resp = s_axi_bresp;
        @(posedge aclk);
        if (aw_go) s_axi_awvalid <= 1'b0;
        if (w_go) s_axi_wvalid <= 1'b0;
    end
endtask
task rd(input [7:0] a);
    reg ar_go, done;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    done = 1'b0;
    while (!done) begin
        @(negedge aclk);
        ar_go = s_axi_arvalid && s_axi_arready;
        done = s_axi_rvalid;
        rd_data = s_axi_rdata;
        resp = s_axi_rresp;
        @(posedge aclk);
        if (ar_go) s_axi_arvalid <= 1'b0;
    end
endtask
task do_reset;
    aresetn <= 1'b0;
    cyc(4);
    aresetn <= 1'b1;
    cyc(1);
endtask
task step(input rev);
    internal_reverse <= rev;
    internal_step <= 1'b1;
    cyc(1);
    internal_step <= 1'b0;
    cyc(2);
endtask
task gear(input [31:0] n, input [31:0] d, input exp);
    wr(8'h08, n);
    wr(8'h0C, d);
    cyc(4);
    chk(parameter_fault_alarm, exp);
endtask
////////////////////////////////////////////////////////////////////////////
task t_reset;
    integer i;
    for (i = 0; i < 7; i = i + 1) begin
        rd(8'(i * 4));
        chk(rd_data, (i > 0 && i < 4) ? 32'h1 : 32'h0);
    end
    chk(multiplier_active_out, 1'b0);
    rd(8'h20);
    chk(rd_data, 32'h0);
    chk(resp, 2'h2);
    wr(8'h18, 32'h5);
    chk(resp, 2'h2);
endtask
task t_forms;
    integer i;
    for (i = 0; i < 3; i = i + 1) begin
        form = (i == 2) ? 3'h4 : i[2:0];
        do_reset;
        wr(8'h00, {23'h0, i[0], 1'b0, form, 4'h0});
        wr(8'h08, 32'h3);
        wr(8'h0C, 32'h5);
        host.emit(1'b0, 6);
        host.emit(1'b1, 10);
        cyc(10);
        chk(cnt, 32'h10);
        chk(sum, 32'hFFFFFFFD);
        rd(8'h18);
        chk(rd_data, 32'hFFFFFFFD);
    end
endtask
task t_mult;
    integer i;
    form = 3'h0;
    do_reset;
    wr(8'h04, 32'hC8);
    rd(8'h04);
    chk(rd_data, 32'h64);
    wr(8'h04, 32'h5);
    wr(8'h00, 32'h1);
    cyc(2);
    chk(multiplier_active_out, 1'b1);
    host.emit(1'b0, 2);
    cyc(10);
    chk(sum, 32'hA);
    wr(8'h00, 32'h2);
    for (i = 0; i < 4; i = i + 1) begin
        multiplier_switch <= i[0];
        position_mode <= i[1];
        cyc(8);
        chk(multiplier_active_out, i == 3);
    end
    host.emit(1'b0, 1);
    cyc(10);
    chk(sum, 32'hF);
    multiplier_switch <= 1'b0;
    cyc(8);
    host.emit(1'b0, 1);
    cyc(10);
    chk(sum, 32'h10);
    wr(8'h00, 32'h0);
    cyc(2);
    chk(multiplier_active_out, 1'b0);
    host.emit(1'b0, 1);
    wr(8'h00, 32'h1);
    rd(8'h10);
    chk(rd_data, 32'h2);
endtask
task t_gear;
    do_reset;
    wr(8'h14, 32'h1);
    gear(32'hFA00, 32'h1, 1'b0);
    gear(32'hFA01, 32'h1, 1'b1);
    gear(32'h1, 32'h3E8, 1'b0);
    chk(irq, 1'b1);
    wr(8'h10, 32'h1);
    chk(irq, 1'b0);
    gear(32'h1, 32'h3E9, 1'b1);
    gear(32'h5, 32'h0, 1'b1);
    wr(8'h14, 32'h0);
    chk(irq, 1'b0);
    do_reset;
    wr(8'h08, 32'h0);
    wr(8'h0C, 32'h400);
    host.emit(1'b0, 3);
    cyc(10);
    chk(sum, 32'hC000);
    chk(parameter_fault_alarm, 1'b0);
endtask
task t_source;
    do_reset;
    wr(8'h00, 32'h300);
    rd(8'h00);
    chk(rd_data, 32'h300);
    step(1'b0);
    step(1'b0);
    step(1'b1);
    host.emit(1'b0, 2);
    cyc(10);
    chk(cnt, 32'h3);
    chk(sum, 32'h1);
    wr(8'h00, 32'h200);
    step(1'b0);
    host.emit(1'b0, 1);
    cyc(10);
    chk(cnt, 32'h3);
endtask
task complete_run;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
        $display("== PASSED ==");
    else
        $display("== FAILED ==");
    $finish;
endtask
initial begin
    cyc(20000);
    num_errors = num_errors + 1;
    complete_run;
end
initial begin
    {num_errors, checked} = 0;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h1;
    {s_axi_arvalid, s_axi_rready, multiplier_switch} = 3'h2;
    {internal_step, internal_reverse, position_mode} = 3'h1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    form = 3'h0;
    cyc(16);
    aresetn <= 1'b1;
    cyc(1);
    t_reset;
    t_forms;
    t_mult;
    t_gear;
    t_source;
    complete_run;
end
endmodule // tb_top
